// ### src/rcd_decode.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - opcode is top four bits, then destination, then first source.
// - register specifiers are six bits; only 48 general registers exist.
// - store data, load and arithmetic destinations share one field.
// - single-source forms keep registers high, displacement in low halfword.
// - opcode msb set marks every 16 bit displacement format.
// - opcodes 0..7 decode trap through CPU arithmetic in order.
// - opcodes 8..15 decode reserved through add immediate in order.
// - registers 48..63 are special, never reachable by coprocessor instructions.
// - illegal special source reads give undefined data, no exception.
// - status word as destination writes nothing.
// - program counter readable as first source only.
// - pc queue holds four stage pcs, advancing only outside kernel mode.
// - on trap, writeback pc then three following instruction addresses.
// - bubbles carry the pc of the next valid instruction behind.
// - queue read returns writeback pc; queue write loads fetch pc.
// - queue-exit read returns writeback pc, leaves kernel one instruction later.
// - coprocessor specifiers form one six bit address space.
// - addresses 55..63 belong to the cache controller.
// - opcode 0 traps in user mode, no-op in kernel mode.
// - trap interrupt asserted in the instruction's writeback stage.
// - trap literal is kept in no register.
module rcd_decode
(
  input  wire  logic        sys_clk,
  input  wire  logic        rst,
  input  wire  logic        ce,
  input  wire  logic        instr_valid,
  input  wire  logic [31:0] instr,
  input  wire  logic        advance,
  input  wire  logic        kernel_mode,
  input  wire  logic [31:0] next_pc,
  input  wire  logic [31:0] result_data,
  input  wire  logic        result_valid,
  output rcd_pkg::rcd_op_t  op_q,
  output logic [5:0]        result_reg_field,
  output logic [5:0]        first_source_field,
  output logic [5:0]        second_source_field,
  output logic [15:0]       displacement,
  output logic              disp_format,
  output logic              gpr_write_en,
  output logic              cop_access,
  output logic              cop_to_float,
  output logic              cop_to_cache,
  output logic [5:0]        cop_addr,
  output logic              src_a_special,
  output logic              src_b_special,
  output logic              src_a_undef,
  output logic              src_b_undef,
  output logic [31:0]       special_rd_data_q,
  output logic              pcq_write,
  output logic              leave_kernel_q,
  output logic              sw_interrupt,
  output logic [31:0]       fetch_stage_pc,
  output logic [31:0]       execute_stage_pc,
  output logic [31:0]       memory_stage_pc,
  output logic [31:0]       writeback_stage_pc
);
  import rcd_pkg::*;

  // ****************
  // field extraction
  // ****************
  logic [3:0] opc;
  logic [5:0] rr, ra, rb;
  rcd_op_t    op_d;
  logic       is_alu, is_addi, is_vextr, dest_capable;

  assign opc = instr[OPC_HI:OPC_LO];
  assign rr  = instr[RR_HI:RR_LO];
  assign ra  = instr[RA_HI:RA_LO];
  assign rb  = instr[RB_HI:RB_LO];
  assign result_reg_field    = rr;
  assign first_source_field  = ra;
  assign second_source_field = rb;
  assign displacement = instr[DISP_HI:DISP_LO];
  assign disp_format  = instr[DISP_FMT_BIT];

  // ****************
  // opcode map
  // ****************
  always_comb begin
    op_d = rcd_op_t'(16'h0001 << opc);
  end

  assign is_alu   = (opc == 4'h7);
  assign is_addi  = (opc == 4'hf);
  assign is_vextr = (opc == 4'h3);
  assign dest_capable = (opc == 4'h1) || (opc == 4'h3) || (opc == 4'h5) || is_alu
                        || (opc == 4'hd) || is_addi;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      op_q <= OP_TRAP;
    end else if (ce && instr_valid) begin
      op_q <= op_d;
    end
  end

  // ****************
  // special register checks
  // ****************
  logic ra_ok, rb_ok, cop_op;

  assign src_a_special = (ra >= SPECIAL_LO);
  assign src_b_special = (rb >= SPECIAL_LO);
  // pc only as first source; others not as first source
  assign ra_ok = !src_a_special || (ra == REG_PC);
  assign rb_ok = !src_b_special || (((rb == REG_PSW) || (rb == REG_PCQ) || (rb == REG_PC_HISTORY_QUEUE_EXIT))
                                    && (is_alu || is_vextr));
  // undefined data only, never an exception
  assign src_a_undef = instr_valid && !ra_ok;
  assign src_b_undef = instr_valid && !rb_ok;

  // status word destination dropped, specials only by alu or add imm
  assign gpr_write_en = instr_valid && dest_capable && (rr != REG_PSW)
                        && ((rr <= GPR_LAST) || ((is_alu || is_addi) && (rr >= REG_PCQ)));

  // ****************
  // coprocessor address space
  // ****************
  assign cop_op     = (opc == 4'h4) || (opc == 4'h5) || (opc == 4'h6) || (opc == 4'ha) || (opc == 4'hb);
  assign cop_access = instr_valid && cop_op;
  // cop instructions name coprocessor registers, never cpu specials
  assign cop_addr     = (opc == 4'ha || opc == 4'hb) ? rr : (opc == 4'h6 ? rr : ra);
  assign cop_to_float = cop_access && (cop_addr <= FPU_LAST);
  assign cop_to_cache = cop_access && (cop_addr >= CCU_FIRST);

  // ****************
  // pc history queue
  // ****************
  logic wr_pcq;
  assign wr_pcq    = ce && result_valid && (rr == REG_PCQ) && (is_alu || is_addi);
  assign pcq_write = wr_pcq;

  rcd_pc_queue u_pcq (
    .sys_clk            (sys_clk),
    .rst                (rst),
    .ce                 (ce),
    .advance            (advance),       // bubbles repeat the pc behind
    .kernel_mode        (kernel_mode),
    .next_pc            (next_pc),
    .wr_en              (wr_pcq),
    .wr_data            (result_data),
    .fetch_stage_pc     (fetch_stage_pc),
    .execute_stage_pc   (execute_stage_pc),
    .memory_stage_pc    (memory_stage_pc),
    .writeback_stage_pc (writeback_stage_pc)
  );

  // read of queue or queue-exit returns writeback pc
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      special_rd_data_q <= UNDEF_DATA;
    end else if (ce && instr_valid) begin
      if ((rb == REG_PCQ) || (rb == REG_PC_HISTORY_QUEUE_EXIT)) begin
        special_rd_data_q <= writeback_stage_pc;
      end else if (ra == REG_PC) begin
        special_rd_data_q <= fetch_stage_pc;
      end else begin
        special_rd_data_q <= UNDEF_DATA;
      end
    end
  end

  // kernel exit after one instruction of delay
  logic exit_pend_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      exit_pend_q    <= 1'b0;
      leave_kernel_q <= 1'b0;
    end else if (ce) begin
      leave_kernel_q <= 1'b0;
      if (instr_valid && advance && rb == REG_PC_HISTORY_QUEUE_EXIT && (is_alu || is_vextr)) begin
        exit_pend_q <= 1'b1;
      end else if (exit_pend_q && advance) begin
        exit_pend_q    <= 1'b0;
        leave_kernel_q <= 1'b1;
      end
    end
  end

  // ****************
  // trap pipe to writeback
  // ****************
  logic [2:0] trap_pipe_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trap_pipe_q <= 3'h0;
    end else if (ce && advance) begin
      // literal deliberately dropped here
      trap_pipe_q <= {trap_pipe_q[1:0], instr_valid && (opc == 4'h0) && !kernel_mode};
    end
  end
  assign sw_interrupt = trap_pipe_q[2] && !kernel_mode;

  // ****************
  // checks
  // ****************
  property p_psw_no_write;
    @(posedge sys_clk) disable iff (rst)
      (instr_valid && rr == REG_PSW) |-> !gpr_write_en;
  endproperty
  a_psw_no_write: assert property (p_psw_no_write) else $error("status word written");

  property p_pc_not_second;
    @(posedge sys_clk) disable iff (rst)
      (instr_valid && rb == REG_PC) |-> src_b_undef;
  endproperty
  a_pc_not_second: assert property (p_pc_not_second) else $error("pc accepted as second source");

  property p_pc_first_ok;
    @(posedge sys_clk) disable iff (rst)
      (instr_valid && ra == REG_PC) |-> !src_a_undef;
  endproperty
  a_pc_first_ok: assert property (p_pc_first_ok) else $error("pc refused as first source");

  property p_disp_msb;
    @(posedge sys_clk) disable iff (rst)
      instr_valid |-> (disp_format == (|op_d[15:8]));
  endproperty
  a_disp_msb: assert property (p_disp_msb) else $error("displacement format mismatch");

  property p_cop_split;
    @(posedge sys_clk) disable iff (rst)
      cop_access |-> (cop_to_float ^ cop_to_cache);
  endproperty
  a_cop_split: assert property (p_cop_split) else $error("coprocessor address not split");

  sequence s_user_trap;
    ce && advance && instr_valid && opc == 4'h0 && !kernel_mode;
  endsequence
  property p_trap_wb;
    @(posedge sys_clk) disable iff (rst)
      (s_user_trap ##1 (ce && advance && !kernel_mode) [*3]) |-> sw_interrupt;
  endproperty
  a_trap_wb: assert property (p_trap_wb) else $error("trap not raised in writeback");

  property p_kernel_trap_nop;
    @(posedge sys_clk) disable iff (rst)
      kernel_mode |-> !sw_interrupt;
  endproperty
  a_kernel_trap_nop: assert property (p_kernel_trap_nop) else $error("trap in kernel mode");

  property p_queue_freeze;
    @(posedge sys_clk) disable iff (rst)
      (ce && kernel_mode && !wr_pcq) |=> $stable(writeback_stage_pc) && $stable(memory_stage_pc);
  endproperty
  a_queue_freeze: assert property (p_queue_freeze) else $error("queue moved in kernel");

  property p_queue_write;
    @(posedge sys_clk) disable iff (rst)
      wr_pcq |=> (fetch_stage_pc == $past(result_data));
  endproperty
  a_queue_write: assert property (p_queue_write) else $error("queue write missed fetch pc");

  property p_exit_read;
    @(posedge sys_clk) disable iff (rst)
      (ce && instr_valid && rb == REG_PC_HISTORY_QUEUE_EXIT) |=> (special_rd_data_q == $past(writeback_stage_pc));
  endproperty
  a_exit_read: assert property (p_exit_read) else $error("exit read not writeback pc");

  property p_exit_pulse;
    @(posedge sys_clk) disable iff (rst)
      (ce && leave_kernel_q) |=> !leave_kernel_q;
  endproperty
  a_exit_pulse: assert property (p_exit_pulse) else $error("kernel exit pulse too long");

  sequence s_exit_read;
    ce && advance && instr_valid && rb == REG_PC_HISTORY_QUEUE_EXIT && (is_alu || is_vextr);
  endsequence
  sequence s_exit_next;
    ce && advance && !(instr_valid && rb == REG_PC_HISTORY_QUEUE_EXIT && (is_alu || is_vextr));
  endsequence
  property p_exit_delay;
    @(posedge sys_clk) disable iff (rst)
      (s_exit_read ##1 s_exit_next) |=> leave_kernel_q;
  endproperty
  a_exit_delay: assert property (p_exit_delay) else $error("kernel exit not one instruction later");

  // ****************
  // pipeline, opcode decode and register checks
  // ****************
  sequence s_kernel_trap;
    ce && advance && instr_valid && opc == 4'h0 && kernel_mode;
  endsequence
  property p_kernel_trap_drop;
    @(posedge sys_clk) disable iff (rst)
      s_kernel_trap |=> !trap_pipe_q[0];
  endproperty
  a_kernel_trap_drop: assert property (p_kernel_trap_drop) else $error("kernel trap entered pipe");

  property p_fetch_advance;
    @(posedge sys_clk) disable iff (rst)
      (ce && advance && !kernel_mode && !wr_pcq) |=>
        (fetch_stage_pc == $past(next_pc)) && (execute_stage_pc == $past(fetch_stage_pc));
  endproperty
  a_fetch_advance: assert property (p_fetch_advance) else $error("queue did not shift");

  property p_bubble_hold;
    @(posedge sys_clk) disable iff (rst)
      (ce && !advance && !wr_pcq) |=> $stable(fetch_stage_pc) && $stable(writeback_stage_pc);
  endproperty
  a_bubble_hold: assert property (p_bubble_hold) else $error("bubble moved stage pc");

  property p_ce_freeze;
    @(posedge sys_clk) disable iff (rst)
      !ce |=> $stable(op_q) && $stable(special_rd_data_q) && $stable(fetch_stage_pc) && $stable(leave_kernel_q);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with clock enable low");

  property p_op_trap;
    @(posedge sys_clk) disable iff (rst)
      (ce && instr_valid && opc == 4'h0) |=> (op_q == OP_TRAP);
  endproperty
  a_op_trap: assert property (p_op_trap) else $error("opcode 0 not trap");

  property p_op_addi;
    @(posedge sys_clk) disable iff (rst)
      (ce && instr_valid && opc == 4'hf) |=> (op_q == OP_ADDI);
  endproperty
  a_op_addi: assert property (p_op_addi) else $error("opcode 15 not add immediate");

  property p_undef_special;
    @(posedge sys_clk) disable iff (rst)
      !(src_a_undef && !src_a_special) && !(src_b_undef && !src_b_special);
  endproperty
  a_undef_special: assert property (p_undef_special) else $error("general register read flagged");

  property p_reserved_dest;
    @(posedge sys_clk) disable iff (rst)
      (instr_valid && rr >= SPECIAL_LO && rr < REG_PCQ) |-> !gpr_write_en;
  endproperty
  a_reserved_dest: assert property (p_reserved_dest) else $error("reserved special written");

  property p_cop_no_gpr;
    @(posedge sys_clk) disable iff (rst)
      (instr_valid && (opc == 4'h4 || opc == 4'h6 || opc == 4'ha || opc == 4'hb)) |-> !gpr_write_en;
  endproperty
  a_cop_no_gpr: assert property (p_cop_no_gpr) else $error("coprocessor op wrote cpu register");
endmodule
`default_nettype wire

// ### shared/rcd_pkg.sv
`default_nettype none
package rcd_pkg;
  // ****************
  // instruction fields
  // ****************
  localparam int OPC_HI       = 31;
  localparam int OPC_LO       = 28;
  localparam int RR_HI        = 27;
  localparam int RR_LO        = 22;
  localparam int RA_HI        = 21;
  localparam int RA_LO        = 16;
  localparam int RB_HI        = 15;
  localparam int RB_LO        = 10;
  localparam int DISP_HI      = 15;
  localparam int DISP_LO      = 0;
  localparam int LIT_HI       = 27;
  localparam int LIT_LO       = 0;
  localparam int DISP_FMT_BIT = 31;

  // ****************
  // register space
  // ****************
  localparam logic [5:0] GPR_LAST    = 6'h2f;
  localparam logic [5:0] SPECIAL_LO  = 6'h30;
  localparam logic [5:0] REG_PCQ     = 6'h3c;
  localparam logic [5:0] REG_PC_HISTORY_QUEUE_EXIT    = 6'h3d;
  localparam logic [5:0] REG_PSW     = 6'h3e;
  localparam logic [5:0] REG_PC      = 6'h3f;
  localparam logic [5:0] FPU_LAST    = 6'h36;
  localparam logic [5:0] CCU_FIRST   = 6'h37;
  localparam logic [31:0] PC_RESET   = 32'h0000_0000;
  localparam logic [31:0] UNDEF_DATA = 32'h0000_0000;

  typedef enum logic [15:0] {
    OP_TRAP    = 16'h0001,
    OP_EXTR    = 16'h0002,
    OP_UNDEF   = 16'h0004,
    OP_VEXTR   = 16'h0008,
    OP_TO_COP  = 16'h0010,
    OP_FROM_COP= 16'h0020,
    OP_COP_ALU = 16'h0040,
    OP_ALU     = 16'h0080,
    OP_UNDEF_B = 16'h0100,
    OP_TEST    = 16'h0200,
    OP_COP_ST  = 16'h0400,
    OP_COP_LD  = 16'h0800,
    OP_ST      = 16'h1000,
    OP_LD      = 16'h2000,
    OP_JUMP    = 16'h4000,
    OP_ADDI    = 16'h8000
  } rcd_op_t;
endpackage
`default_nettype wire

// ### src/rcd_pc_queue.sv
`timescale 1ns/1ps
`default_nettype none
// four-entry stage pc history
module rcd_pc_queue
(
  input  wire  logic        sys_clk,
  input  wire  logic        rst,
  input  wire  logic        ce,
  input  wire  logic        advance,
  input  wire  logic        kernel_mode,
  input  wire  logic [31:0] next_pc,
  input  wire  logic        wr_en,
  input  wire  logic [31:0] wr_data,
  output logic [31:0] fetch_stage_pc,
  output logic [31:0] execute_stage_pc,
  output logic [31:0] memory_stage_pc,
  output logic [31:0] writeback_stage_pc
);
  import rcd_pkg::*;

  logic [31:0] q [4];
  genvar g;

  // entry 0 fetch; higher entries are later stages
  generate
    for (g = 0; g < 4; g++) begin : g_ent
      if (g == 0) begin : g_head
        // write has priority over the shift
        always_ff @(posedge sys_clk or posedge rst) begin
          if (rst) begin
            q[g] <= PC_RESET;
          end else if (ce) begin
            if (wr_en) begin
              q[g] <= wr_data;
            end else if (advance && !kernel_mode) begin
              q[g] <= next_pc;
            end
          end
        end
      end else begin : g_tail
        always_ff @(posedge sys_clk or posedge rst) begin
          if (rst) begin
            q[g] <= PC_RESET;
          end else if (ce && advance && !kernel_mode) begin
            q[g] <= q[g-1];
          end
        end
      end
    end
  endgenerate

  assign fetch_stage_pc     = q[0];
  assign execute_stage_pc   = q[1];
  assign memory_stage_pc    = q[2];
  assign writeback_stage_pc = q[3];
endmodule
`default_nettype wire

// ### sim/rcd_cop_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// coprocessor and cache controller address responders
// ****************
module rcd_cop_model (
  input  wire logic       cop_access,
  input  wire logic [5:0] cop_addr,
  input  wire logic       kernel_mode,
  output logic            float_sel,
  output logic            cache_sel,
  output logic            cache_irq
);
  // one shared six bit space, split between the two chips
  assign float_sel = cop_access && (cop_addr <= 6'h36);
  assign cache_sel = cop_access && (cop_addr >= 6'h37);
  // user access to cache controller registers may interrupt
  assign cache_irq = cache_sel && !kernel_mode;
endmodule
`default_nettype wire

// ### sim/rcd_decode_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rcd_decode_tb_top;
  import rcd_pkg::*;
  logic sys_clk, rst, ce, instr_valid, advance, kernel_mode, result_valid;
  logic [31:0] instr, next_pc, result_data;
  rcd_op_t op_q;
  logic [5:0] result_reg_field, first_source_field, second_source_field, cop_addr;
  logic [15:0] displacement;
  logic disp_format, gpr_write_en, cop_access, cop_to_float, cop_to_cache;
  logic src_a_special, src_b_special, src_a_undef, src_b_undef, pcq_write, leave_kernel_q, sw_interrupt;
  logic [31:0] special_rd_data_q, fetch_stage_pc, execute_stage_pc, memory_stage_pc, writeback_stage_pc;
  logic float_sel, cache_sel, cache_irq;
  int n_errors = 0;
  int check_count = 0;

  rcd_decode DUT (.sys_clk(sys_clk), .rst(rst), .ce(ce), .instr_valid(instr_valid), .instr(instr),
    .advance(advance), .kernel_mode(kernel_mode), .next_pc(next_pc), .result_data(result_data),
    .result_valid(result_valid), .op_q(op_q), .result_reg_field(result_reg_field),
    .first_source_field(first_source_field), .second_source_field(second_source_field),
    .displacement(displacement), .disp_format(disp_format), .gpr_write_en(gpr_write_en),
    .cop_access(cop_access), .cop_to_float(cop_to_float), .cop_to_cache(cop_to_cache),
    .cop_addr(cop_addr), .src_a_special(src_a_special), .src_b_special(src_b_special),
    .src_a_undef(src_a_undef), .src_b_undef(src_b_undef), .special_rd_data_q(special_rd_data_q),
    .pcq_write(pcq_write), .leave_kernel_q(leave_kernel_q), .sw_interrupt(sw_interrupt),
    .fetch_stage_pc(fetch_stage_pc), .execute_stage_pc(execute_stage_pc),
    .memory_stage_pc(memory_stage_pc), .writeback_stage_pc(writeback_stage_pc));

  rcd_cop_model partner (.cop_access(cop_access), .cop_addr(cop_addr), .kernel_mode(kernel_mode),
    .float_sel(float_sel), .cache_sel(cache_sel), .cache_irq(cache_irq));

  // ****************
  // shared helpers
  // ****************
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  function automatic logic [31:0] mk(input logic [3:0] op, input logic [5:0] rr, ra, rb);
    return {op, rr, ra, rb, 10'h000};
  endfunction

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_fields;
    for (int i = 0; i < 16; i++) begin
      instr = {i[3:0], 6'h2a, 6'h15, 16'hcd5a};
      #1;
      chk(result_reg_field, 32'h2a, "rr field");
      chk(first_source_field, 32'h15, "ra field");
      chk(second_source_field, 32'h33, "rb field");
      chk(displacement, 32'hcd5a, "displacement");
      chk(disp_format, i[3], "disp format");
      cyc(1);
      chk(op_q, 32'h1 << i, "opcode decode");
    end
    $display("test fields done");
  endtask

  task automatic t_specials;
    instr = mk(4'h7, 6'h3e, 6'h3e, 6'h3e);
    #1;
    chk(gpr_write_en, 1'b0, "status word write");
    cyc(1);
    instr = mk(4'h7, 6'h01, 6'h3f, 6'h3f);
    #1;
    chk(src_a_undef, 1'b0, "pc as first source");
    chk(src_b_undef, 1'b1, "pc as second source");
    cyc(1);
    instr = mk(4'h7, 6'h2f, 6'h30, 6'h2f);
    #1;
    chk({src_a_special, src_b_special, gpr_write_en}, 3'b101, "special bounds");
    cyc(1);
    $display("test specials done");
  endtask

  task automatic t_cop;
    logic [5:0] a[4] = '{6'h00, 6'h36, 6'h37, 6'h3f};
    foreach (a[k]) begin
      instr = mk(4'hb, a[k], 6'h00, 6'h00);
      #1;
      chk(cop_addr, a[k], "cop load addr");
      chk({cop_to_float, cop_to_cache}, {float_sel, cache_sel}, "cop split");
      chk(cache_irq, cop_to_cache, "user cache access");
      chk(cop_access, 1'b1, "cop access");
      cyc(1);
    end
    instr = mk(4'h4, 6'h05, 6'h37, 6'h00);
    #1;
    chk({cop_addr, cop_to_cache}, {6'h37, 1'b1}, "transfer addr");
    cyc(1);
    $display("test cop done");
  endtask

  task automatic t_queue;
    instr = mk(4'h7, 6'h3e, 6'h3e, 6'h3e);
    for (int i = 0; i < 4; i++) begin
      next_pc = 32'h100 + 4 * i;
      cyc(1);
    end
    chk({fetch_stage_pc[15:0], execute_stage_pc[15:0]}, 32'h010c_0108, "queue order front");
    chk({memory_stage_pc[15:0], writeback_stage_pc[15:0]}, 32'h0104_0100, "queue order back");
    advance = 1'b0;
    next_pc = 32'h200;
    cyc(2);
    chk(fetch_stage_pc, 32'h10c, "bubble holds");
    advance = 1'b1;
    kernel_mode = 1'b1;
    cyc(2);
    chk(writeback_stage_pc, 32'h100, "kernel holds");
    kernel_mode = 1'b0;
    advance = 1'b0;
    instr = mk(4'h7, 6'h01, 6'h00, 6'h3c);
    cyc(1);
    chk(special_rd_data_q, 32'h100, "queue read");
    instr = mk(4'h7, 6'h3c, 6'h00, 6'h00);
    result_data = 32'h5000;
    result_valid = 1'b1;
    #1;
    chk(pcq_write, 1'b1, "queue write strobe");
    cyc(1);
    chk(fetch_stage_pc, 32'h5000, "queue write");
    result_valid = 1'b0;
    $display("test queue done");
  endtask

  task automatic t_exit;
    logic [31:0] hits = '0;
    kernel_mode = 1'b1;
    advance = 1'b1;
    instr = mk(4'h7, 6'h01, 6'h00, 6'h3d);
    cyc(1);
    chk(special_rd_data_q, 32'h100, "exit read");
    instr = mk(4'h7, 6'h3e, 6'h3e, 6'h3e);
    for (int i = 0; i < 3; i++) begin
      hits += leave_kernel_q;
      cyc(1);
    end
    chk(hits, 1, "kernel exit pulse");
    $display("test exit done");
  endtask

  task automatic t_trap(input logic km);
    kernel_mode = km;
    instr = {4'h0, 28'habcdef0};
    cyc(1);
    // user mode from here, so a kernel trap must already be gone
    kernel_mode = 1'b0;
    instr = mk(4'h7, 6'h3e, 6'h3e, 6'h3e);
    chk(sw_interrupt, 1'b0, "trap early");
    cyc(1);
    chk(sw_interrupt, 1'b0, "trap early");
    cyc(1);
    chk(sw_interrupt, !km, "trap at writeback");
    chk(special_rd_data_q === 32'habcdef0, 1'b0, "literal kept");
    cyc(2);
    kernel_mode = 1'b0;
    $display("test trap done");
  endtask

  task automatic t_hold_reset;
    next_pc = 32'h300;
    cyc(1);
    ce = 1'b0;
    next_pc = 32'h400;
    instr = {4'hf, 28'h0};
    cyc(2);
    chk(fetch_stage_pc, 32'h300, "enable low holds queue");
    chk(op_q, OP_ALU, "enable low holds opcode");
    ce = 1'b1;
    cyc(1);
    chk(fetch_stage_pc, 32'h400, "enable high shifts queue");
    chk(op_q, OP_ADDI, "enable high decodes");
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    chk(fetch_stage_pc, PC_RESET, "reset fetch pc");
    chk(op_q, OP_TRAP, "reset opcode");
    cyc(1);
    chk(fetch_stage_pc, 32'h400, "first edge after reset");
    chk(writeback_stage_pc, PC_RESET, "writeback after reset");
    $display("test hold done");
  endtask

  initial begin
    #4000;
    n_errors++;
    close_out;
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    instr_valid = 1'b1;
    advance = 1'b1;
    kernel_mode = 1'b0;
    result_valid = 1'b0;
    instr = '0;
    next_pc = '0;
    result_data = '0;
    cyc(16);
    rst = 1'b0;
    t_fields;
    t_specials;
    t_cop;
    t_queue;
    t_exit;
    t_trap(1'b0);
    t_trap(1'b1);
    t_hold_reset;
    close_out;
  end
endmodule
`default_nettype wire
